// [apc_active_power.sv]
// Per-phase active power calibration, energy first stage and sign detection
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "apc_map.svh"
module apc_active_power #(
    parameter int SETTLE_CYCLES = `APC_SETTLE_S * `APC_CLK_HZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Register port
    input wire apc_pkg::apc_bus_t bus_in,
    output logic [31:0] rdata_out,
    // Filtered powers, three phases, with DSP update strobe
    input wire apc_pkg::apc_power_t [2:0] lpf_in,
    input wire logic update_in,
    // Accumulation tick, one-cycle enable at the accumulation rate
    input wire logic acc_tick_in,
    // Calibrated powers
    output apc_pkg::apc_power_t [2:0] cal_out,
    output logic cal_valid_out,
    // Status outputs
    output logic line_freq_range_select_out,
    output logic settling_out,
    output logic interrupt_out_n
);
    import apc_pkg::*;

    // Sign-extend 24-bit register to the 28-bit DSP width
    function automatic logic [27:0] sext28(input logic [23:0] v);
        sext28 = {{4{v[23]}}, v};
    endfunction

    // Pick the three per-phase event bits out of a bus word
    function automatic logic [2:0] rev_bits(input logic [31:0] w);
        rev_bits = w[`APC_REV_LSB+2:`APC_REV_LSB];
    endfunction

    // Zero-pad a 24-bit register to the 32-bit bus word
    function automatic logic [31:0] pad24(input logic [23:0] v);
        pad24 = {8'h00, v};
    endfunction

    // Zero-pad a 28-bit DSP word to the 32-bit bus word
    function automatic logic [31:0] pad28(input logic [27:0] v);
        pad28 = {4'h0, v};
    endfunction

    // Offset then gain: (p + os) * (1 + g / 2^23)
    function automatic logic [27:0] calib(input logic [27:0] p, input logic [23:0] g,
                                          input logic [23:0] os);
        logic signed [28:0] sum;
        logic signed [53:0] prod;
        logic signed [53:0] scaled;
        // Sum is one bit wider so a large offset cannot wrap before scaling
        sum = $signed({p[27], p}) + $signed({os[23], sext28(os)});
        prod = $signed(sum) * $signed(sext28(g));
        // Arithmetic shift floors the product; the result wraps to 28 bits
        scaled = $signed({{25{sum[28]}}, sum}) + (prod >>> `APC_GAIN_FRAC);
        calib = scaled[27:0];
    endfunction

    // Register state
    logic [23:0] gain_r [3];
    logic [23:0] gain_nxt [3];
    logic [23:0] tos_r [3];
    logic [23:0] tos_nxt [3];
    logic [23:0] fos_r [3];
    logic [23:0] fos_nxt [3];
    logic [15:0] comp_r, comp_nxt;
    logic [7:0] accm_r, accm_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic [2:0] flag_r, flag_nxt;
    logic [2:0] en_r, en_nxt;
    logic [2:0] sign_r, sign_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_n_r, irq_n_nxt;
    // First stage accumulators, one per phase
    logic signed [36:0] acc_r [3];
    logic signed [36:0] acc_nxt [3];
    logic [2:0] last_sign_r, last_sign_nxt;
    // One-cycle sign change events, combinational
    logic [2:0] change;
    // Calibrated power path
    apc_power_t [2:0] cal_r, cal_nxt;
    logic cal_valid_r, cal_valid_nxt;
    // Frequency settling timer
    apc_state_t st_r, st_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic fsel_d_r;
    // Next delayed select and registered settling flag
    logic fsel_d_nxt;
    logic settling_r, settling_nxt;

    // Register writes and read data
    always_comb begin
        gain_nxt = gain_r;
        tos_nxt = tos_r;
        fos_nxt = fos_r;
        comp_nxt = comp_r;
        accm_nxt = accm_r;
        thr_nxt = thr_r;
        en_nxt = en_r;
        rdata_nxt = 32'h0000_0000;
        // Unused bus bits are dropped; fields sit at the bottom, except the enable and flag bits at 8:6
        if (bus_in.wr) begin
            case (bus_in.addr)
                `APC_OFF_GAIN_A: gain_nxt[0] = bus_in.wdata[23:0];
                `APC_OFF_GAIN_B: gain_nxt[1] = bus_in.wdata[23:0];
                `APC_OFF_GAIN_C: gain_nxt[2] = bus_in.wdata[23:0];
                `APC_OFF_TOS_A: tos_nxt[0] = bus_in.wdata[23:0];
                `APC_OFF_TOS_B: tos_nxt[1] = bus_in.wdata[23:0];
                `APC_OFF_TOS_C: tos_nxt[2] = bus_in.wdata[23:0];
                `APC_OFF_FOS_A: fos_nxt[0] = bus_in.wdata[23:0];
                `APC_OFF_FOS_B: fos_nxt[1] = bus_in.wdata[23:0];
                `APC_OFF_FOS_C: fos_nxt[2] = bus_in.wdata[23:0];
                `APC_OFF_COMPUTATION_MODE_REG: comp_nxt = bus_in.wdata[15:0];
                `APC_OFF_ACCUMULATION_MODE_REG: accm_nxt = bus_in.wdata[7:0];
                `APC_OFF_THR: thr_nxt = bus_in.wdata[7:0];
                `APC_OFF_ENABLE: en_nxt = rev_bits(bus_in.wdata);
                // Flag clears live with the flags so a same-cycle set can win
                default: ;
            endcase
        end
        if (bus_in.rd) begin
            case (bus_in.addr)
                `APC_OFF_GAIN_A: rdata_nxt = pad24(gain_r[0]);
                `APC_OFF_GAIN_B: rdata_nxt = pad24(gain_r[1]);
                `APC_OFF_GAIN_C: rdata_nxt = pad24(gain_r[2]);
                `APC_OFF_TOS_A: rdata_nxt = pad24(tos_r[0]);
                `APC_OFF_TOS_B: rdata_nxt = pad24(tos_r[1]);
                `APC_OFF_TOS_C: rdata_nxt = pad24(tos_r[2]);
                `APC_OFF_FOS_A: rdata_nxt = pad24(fos_r[0]);
                `APC_OFF_FOS_B: rdata_nxt = pad24(fos_r[1]);
                `APC_OFF_FOS_C: rdata_nxt = pad24(fos_r[2]);
                `APC_OFF_COMPUTATION_MODE_REG: rdata_nxt = {16'h0000, comp_r};
                `APC_OFF_ACCUMULATION_MODE_REG: rdata_nxt = {24'h000000, accm_r};
                `APC_OFF_THR: rdata_nxt = {24'h000000, thr_r};
                `APC_OFF_FLAGS: rdata_nxt = {23'h000000, flag_r, 6'h00};
                `APC_OFF_ENABLE: rdata_nxt = {23'h000000, en_r, 6'h00};
                `APC_OFF_SIGN: rdata_nxt = {29'h00000000, sign_r};
                `APC_OFF_PWR_BASE: rdata_nxt = pad28(cal_r[0].total);
                `APC_OFF_PWR_BASE + 5'h01: rdata_nxt = pad28(cal_r[1].total);
                `APC_OFF_PWR_BASE + 5'h02: rdata_nxt = pad28(cal_r[2].total);
                // Holes in the map read zero so software can probe safely
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // First stage accumulation, sign detection, flags and interrupt
    always_comb begin
        logic signed [36:0] thr;
        logic signed [36:0] sample;
        logic [27:0] src;
        thr = $signed({2'b00, thr_r, {`APC_THR_ZEROS{1'b0}}});
        sample = '0;
        src = '0;
        acc_nxt = acc_r;
        last_sign_nxt = last_sign_r;
        sign_nxt = sign_r;
        change = 3'b000;
        // Each phase accumulates the power picked by the source bit
        for (int i = 0; i < 3; i++) begin
            src = accm_r[`APC_SIGN_SRC_BIT] ? cal_r[i].fund : cal_r[i].total;
            sample = $signed({{9{src[27]}}, src});
            if (acc_tick_in) begin
                acc_nxt[i] = acc_r[i] + sample;
                // Threshold is taken off toward zero so the residue keeps its sign
                if (acc_nxt[i] >= thr || acc_nxt[i] <= -thr) begin
                    if (acc_nxt[i] < 0) begin
                        acc_nxt[i] = acc_nxt[i] + thr;
                    end else begin
                        acc_nxt[i] = acc_nxt[i] - thr;
                    end
                    // Sign of the crossing sample is the sign of the power
                    last_sign_nxt[i] = sample[36];
                    // Only a change against the last crossing raises the event
                    if (sample[36] != last_sign_r[i]) begin
                        change[i] = 1'b1;
                        sign_nxt[i] = sample[36];
                    end
                end
            end
        end
        // Set wins over a write-one clear
        flag_nxt = flag_r;
        if (bus_in.wr && bus_in.addr == `APC_OFF_FLAGS) begin
            flag_nxt = flag_r & ~rev_bits(bus_in.wdata);
        end
        flag_nxt = flag_nxt | change;
        // Next-state terms keep the pin in step with the flags it reflects
        irq_n_nxt = ~|(flag_nxt & en_nxt);
    end

    // Gain on every path each DSP update, offset on total and fundamental only
    always_comb begin
        cal_nxt = cal_r;
        // Valid follows the update strobe by one cycle
        cal_valid_nxt = update_in;
        if (update_in) begin
            for (int i = 0; i < 3; i++) begin
                cal_nxt[i].total = calib(lpf_in[i].total, gain_r[i], tos_r[i]);
                cal_nxt[i].fund = calib(lpf_in[i].fund, gain_r[i], fos_r[i]);
                // Reactive and apparent paths take gain only, no offset
                cal_nxt[i].react = calib(lpf_in[i].react, gain_r[i], 24'h000000);
                cal_nxt[i].appar = calib(lpf_in[i].appar, gain_r[i], 24'h000000);
            end
        end
    end

    // Settling timer started on any change of the range select bit
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        case (st_r)
            APC_IDLE: begin
                // Any change of the select bit starts a fresh wait
                if (comp_r[`APC_FREQ_SEL_BIT] != fsel_d_r) begin
                    st_nxt = APC_SETTLING;
                    tmr_nxt = 32'(SETTLE_CYCLES);
                end
            end
            APC_SETTLING: begin
                // A flip in mid-wait restarts the full count
                if (comp_r[`APC_FREQ_SEL_BIT] != fsel_d_r) begin
                    tmr_nxt = 32'(SETTLE_CYCLES);
                end else if (tmr_r <= 32'h0000_0001) begin
                    st_nxt = APC_IDLE;
                    tmr_nxt = 32'h0000_0000;
                end else begin
                    tmr_nxt = tmr_r - 32'h0000_0001;
                end
            end
            default: begin
                // Unreachable; fall back to idle
                st_nxt = APC_IDLE;
                tmr_nxt = 32'h0000_0000;
            end
        endcase
        // Select output lags the mode bit by one cycle; the timer sees the edge
        fsel_d_nxt = comp_r[`APC_FREQ_SEL_BIT];
        settling_nxt = (st_nxt == APC_SETTLING);
    end

    // Register file and read data
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 3; i++) begin
                gain_r[i] <= 24'h000000;
                tos_r[i] <= 24'h000000;
                fos_r[i] <= 24'h000000;
            end
            comp_r <= 16'h0000;
            accm_r <= 8'h00;
            thr_r <= `APC_THR_RESET;
            en_r <= 3'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            gain_r <= gain_nxt;
            tos_r <= tos_nxt;
            fos_r <= fos_nxt;
            comp_r <= comp_nxt;
            accm_r <= accm_nxt;
            thr_r <= thr_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Accumulators, sign history, event flags and interrupt
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 3; i++) begin
                acc_r[i] <= 37'h0;
            end
            flag_r <= 3'h0;
            sign_r <= 3'h0;
            last_sign_r <= 3'h0; // First crossing compares against positive
            irq_n_r <= 1'b1;
        end else begin
            acc_r <= acc_nxt;
            flag_r <= flag_nxt;
            sign_r <= sign_nxt;
            last_sign_r <= last_sign_nxt;
            irq_n_r <= irq_n_nxt;
        end
    end

    // Calibrated power and its valid pulse
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cal_r <= '0;
            cal_valid_r <= 1'b0;
        end else begin
            cal_r <= cal_nxt;
            cal_valid_r <= cal_valid_nxt;
        end
    end

    // Settling timer, delayed select and settling flag
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= APC_IDLE;
            tmr_r <= 32'h0000_0000;
            fsel_d_r <= 1'b0;
            settling_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            fsel_d_r <= fsel_d_nxt;
            settling_r <= settling_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata_out = rdata_r;
    assign cal_out = cal_r;
    assign cal_valid_out = cal_valid_r;
    assign line_freq_range_select_out = fsel_d_r;
    assign settling_out = settling_r;
    assign interrupt_out_n = irq_n_r;
endmodule

// [apc_map.svh]
// Register offsets, field positions, reset values and constants for the power calibration block
`ifndef APC_MAP_SVH
`define APC_MAP_SVH
`define APC_ADDR_W 5
`define APC_OFF_GAIN_A 5'h00
`define APC_OFF_GAIN_B 5'h01
`define APC_OFF_GAIN_C 5'h02
`define APC_OFF_TOS_A 5'h03
`define APC_OFF_TOS_B 5'h04
`define APC_OFF_TOS_C 5'h05
`define APC_OFF_FOS_A 5'h06
`define APC_OFF_FOS_B 5'h07
`define APC_OFF_FOS_C 5'h08
`define APC_OFF_COMPUTATION_MODE_REG 5'h09
`define APC_OFF_ACCUMULATION_MODE_REG 5'h0A
`define APC_OFF_THR 5'h0B
`define APC_OFF_FLAGS 5'h0C
`define APC_OFF_ENABLE 5'h0D
`define APC_OFF_SIGN 5'h0E
`define APC_OFF_PWR_BASE 5'h10
`define APC_FREQ_SEL_BIT 14
`define APC_SIGN_SRC_BIT 6
`define APC_REV_LSB 6
`define APC_GAIN_FRAC 23
`define APC_THR_ZEROS 27
`define APC_THR_RESET 8'h03
`define APC_FULL_SCALE_POWER_CONSTANT 28'h19CE5DE
`define APC_SETTLE_S 10
`define APC_CLK_HZ 100000000
`endif

// [apc_pkg.sv]
// Types shared by the power calibration and sign detection block
`include "apc_map.svh"
package apc_pkg;
    typedef struct packed {
        logic [27:0] total;
        logic [27:0] fund;
        logic [27:0] react;
        logic [27:0] appar;
    } apc_power_t;
    typedef struct packed {
        logic [`APC_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } apc_bus_t;
    typedef enum {APC_IDLE, APC_SETTLING} apc_state_t;
endpackage

// [apc_active_power_monitor.sv]
// Port-level checks for the power calibration block
`timescale 1ns/100ps
`include "apc_map.svh"
module apc_active_power_monitor import apc_pkg::*; #(
    parameter int SETTLE_CYCLES = 50
) (
    // Watched ports
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire apc_pkg::apc_bus_t bus_in,
    input wire logic [31:0] rdata_out,
    input wire logic update_in,
    input wire logic acc_tick_in,
    input wire apc_pkg::apc_power_t [2:0] cal_out,
    input wire logic cal_valid_out,
    input wire logic line_freq_range_select_out,
    input wire logic settling_out,
    input wire logic interrupt_out_n
);
    logic [31:0] run_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Length of the current settling stretch
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_r <= 32'h0;
        end else begin
            run_r <= settling_out ? run_r + 32'h1 : 32'h0;
        end
    end
    // Mode write, and a full flag clear with no tick around it
    sequence s_mode_wr;
        bus_in.wr && bus_in.addr == `APC_OFF_COMPUTATION_MODE_REG;
    endsequence
    sequence s_clear_all;
        !acc_tick_in ##1 bus_in.wr && bus_in.addr == `APC_OFF_FLAGS
            && bus_in.wdata[8:6] == 3'h7 && !acc_tick_in ##1 !acc_tick_in;
    endsequence
    a_valid_after_update: assert property (update_in |=> cal_valid_out)
        else $error("valid missing after update");
    a_cal_holds: assert property (!update_in |=> $stable(cal_out))
        else $error("calibrated power moved without update");
    a_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 32'h0)
        else $error("read data outside read slot");
    a_select_tracks: assert property (s_mode_wr |-> ##2
        line_freq_range_select_out == $past(bus_in.wdata[14], 2))
        else $error("range select not following mode write");
    a_settle_start: assert property ($changed(line_freq_range_select_out)
        |-> ##[0:1] settling_out)
        else $error("no settling after select change");
    a_settle_bound: assert property (run_r <= 32'(SETTLE_CYCLES))
        else $error("settling too long");
    a_irq_clear: assert property (s_clear_all |-> ##[0:1] interrupt_out_n)
        else $error("interrupt held after clear");
    a_irq_cause: assert property ($fell(interrupt_out_n) |->
        $past(acc_tick_in) || $past(acc_tick_in, 2) || $past(bus_in.wr) || $past(bus_in.wr, 2))
        else $error("interrupt without cause");
endmodule

bind apc_active_power apc_active_power_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_apc_mon (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .update_in(update_in), .acc_tick_in(acc_tick_in), .cal_out(cal_out),
    .cal_valid_out(cal_valid_out), .line_freq_range_select_out(line_freq_range_select_out),
    .settling_out(settling_out), .interrupt_out_n(interrupt_out_n));

// [tb_top.sv]
// Self-checking bench for the power calibration block
`timescale 1ns/100ps
`include "apc_map.svh"
module tb_top;
    import apc_pkg::*;
    localparam int SET = 50;
    localparam logic [27:0] Q = 28'h4000000;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    apc_bus_t bus_in = '0;
    apc_power_t [2:0] lpf_in = '0;
    logic update_in = 1'b0;
    logic acc_tick_in = 1'b0;
    logic [31:0] rdata_out;
    apc_power_t [2:0] cal_out;
    logic cal_valid_out, line_freq_range_select_out, settling_out, interrupt_out_n;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] q;
    apc_active_power #(.SETTLE_CYCLES(SET)) u_apc_active_power (.clk_in, .resetn_in,
        .bus_in, .rdata_out, .lpf_in, .update_in, .acc_tick_in, .cal_out, .cal_valid_out,
        .line_freq_range_select_out, .settling_out, .interrupt_out_n);
    // Clock and hang guard
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register bus cycles
    task automatic bw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus_in.addr <= a;
        bus_in.wdata <= d;
        bus_in.wr <= 1'b1;
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask
    task automatic br(input logic [4:0] a);
        @(posedge clk_in);
        bus_in.addr <= a;
        bus_in.rd <= 1'b1;
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        #1 q = rdata_out;
    endtask
    // Expected calibrated power, exact for the chosen stimulus
    function automatic logic [27:0] ecal(input logic [27:0] p, input logic [23:0] o,
                                         input logic [23:0] g);
        longint a;
        longint b;
        a = longint'($signed(p)) + longint'($signed(o));
        b = longint'($signed(g)) + 64'sd8388608;
        return 28'((a * b) >>> 23);
    endfunction
    task automatic upd(input logic [27:0] t);
        @(posedge clk_in);
        for (int k = 0; k < 3; k++) lpf_in[k] <= '{t, -t, t, t + 28'h10};
        update_in <= 1'b1;
        @(posedge clk_in);
        update_in <= 1'b0;
        #1 chk("valid", 32'h1, {31'h0, cal_valid_out});
    endtask
    task automatic cal(input logic [23:0] g, input logic [23:0] o, input logic [27:0] p);
        for (int k = 0; k < 3; k++) begin
            bw(`APC_OFF_GAIN_A + 5'(k), {8'hA5, g});
            bw(`APC_OFF_TOS_A + 5'(k), {8'h5A, o});
            bw(`APC_OFF_FOS_A + 5'(k), {8'h00, -o});
        end
        br(`APC_OFF_GAIN_C);
        chk("gain readback", {8'h00, g}, q);
        upd(p);
        for (int k = 0; k < 3; k++) begin
            chk("total", {4'h0, ecal(p, o, g)}, {4'h0, cal_out[k].total});
            chk("fund", {4'h0, ecal(-p, -o, g)}, {4'h0, cal_out[k].fund});
            chk("react", {4'h0, ecal(p, 24'h0, g)}, {4'h0, cal_out[k].react});
            chk("appar", {4'h0, ecal(p + 28'h10, 24'h0, g)}, {4'h0, cal_out[k].appar});
        end
        br(`APC_OFF_PWR_BASE + 5'h02);
        chk("power read", {4'h0, ecal(p, o, g)}, q);
    endtask
    // One sign round: source, total power, expected signs, expected interrupt level
    task automatic rnd(input logic s, input logic [27:0] t, input logic [2:0] e, input logic i);
        bw(`APC_OFF_ACCUMULATION_MODE_REG, {25'h0, s, 6'h0});
        upd(t);
        repeat (8) begin
            @(posedge clk_in);
            acc_tick_in <= 1'b1;
            @(posedge clk_in);
            acc_tick_in <= 1'b0;
        end
        br(`APC_OFF_FLAGS);
        chk("flags", 32'h1C0, q);
        br(`APC_OFF_SIGN);
        chk("signs", {29'h0, e}, q);
        chk("irq", {31'h0, i}, {31'h0, interrupt_out_n});
        bw(`APC_OFF_FLAGS, 32'h1C0);
        br(`APC_OFF_FLAGS);
        chk("flags cleared", 32'h0, q);
        chk("irq released", 32'h1, {31'h0, interrupt_out_n});
    endtask
    // Main sequence
    initial begin
        void'($urandom(27316));
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        br(`APC_OFF_THR);
        chk("threshold reset", 32'h3, q);
        br(5'h1F);
        chk("unmapped", 32'h0, q);
        bw(`APC_OFF_THR, 32'h1);
        rnd(1'b0, -Q, 3'h7, 1'b1);
        bw(`APC_OFF_ENABLE, 32'h1C0);
        rnd(1'b0, Q, 3'h0, 1'b0);
        rnd(1'b1, Q, 3'h7, 1'b0);
        rnd(1'b1, -Q, 3'h0, 1'b0);
        cal(24'h000000, 24'h0, `APC_FULL_SCALE_POWER_CONSTANT);
        cal(24'hC00000, 24'h0, `APC_FULL_SCALE_POWER_CONSTANT);
        cal(24'h400000, 24'h0, `APC_FULL_SCALE_POWER_CONSTANT);
        cal(24'h800000, 24'h000008, 28'h0000100);
        repeat (6) cal(24'(($urandom_range(15) - 8) << 20), 24'(($urandom_range(4095) - 2048) * 8),
            28'(($urandom_range(4194303) - 2097152) * 8));
        bw(`APC_OFF_COMPUTATION_MODE_REG, 32'h4000);
        repeat (2) @(posedge clk_in);
        #1 chk("select", 32'h1, {31'h0, line_freq_range_select_out});
        chk("settling", 32'h1, {31'h0, settling_out});
        repeat (SET + 4) @(posedge clk_in);
        #1 chk("settled", 32'h0, {31'h0, settling_out});
        br(`APC_OFF_COMPUTATION_MODE_REG);
        chk("mode readback", 32'h4000, q);
        bw(`APC_OFF_COMPUTATION_MODE_REG, 32'h0);
        repeat (SET + 6) @(posedge clk_in);
        #1 chk("settled low", 32'h0, {31'h0, settling_out});
        chk("select low", 32'h0, {31'h0, line_freq_range_select_out});
        bw(`APC_OFF_COMPUTATION_MODE_REG, 32'h4000);
        repeat (2) @(posedge clk_in);
        #1 chk("restep select", 32'h1, {31'h0, line_freq_range_select_out});
        chk("restep settling", 32'h1, {31'h0, settling_out});
        tally_and_finish();
    end
endmodule
